// ---- core/ssb_regs.vh ----
// Constants for the scanner SRAM buffer controller
`ifndef SSB_REGS_VH
`define SSB_REGS_VH
// Pixel period phases
`define SSB_PHASE_LAST 3'h7
`define SSB_PHASE_FIRST 3'h0
// Slot operations
`define SSB_OP_IDLE 3'h0
`define SSB_OP_OFS 3'h1
`define SSB_OP_GAIN 3'h2
`define SSB_OP_WHI 3'h3
`define SSB_OP_WLO 3'h4
`define SSB_OP_HOST 3'h5
// Slot modes
`define SSB_M8S4 2'h0
`define SSB_M8S8 2'h1
`define SSB_M12S4 2'h2
`define SSB_M12S8 2'h3
// Memory size modes
`define SSB_SZ64K 2'h0
`define SSB_SZ128K 2'h1
`define SSB_SZ256K 2'h2
// Memory and coefficient region sizes in bytes
`define SSB_MEM64K 19'h1_0000
`define SSB_MEM128K 19'h2_0000
`define SSB_MEM256K 19'h4_0000
`define SSB_COEF300 19'h0_4000
`define SSB_COEF600 19'h0_8000
// Register file
`define SSB_REG_DRIVE 7'h43
`define SSB_DRV_LSB 2
`define SSB_DRV_MSB 3
`define SSB_RO_LAST 7'h02
`define SSB_REG_ST0 7'h00
`define SSB_REG_ST1 7'h01
`define SSB_REG_ST2 7'h02
`define SSB_REG_RST 8'h00
`endif

// ---- core/ssb_addr_map.v ----
// Maps a linear SRAM byte address onto the eighteen address pins
`timescale 1ns/1ps
`include "ssb_regs.vh"
module ssb_addr_map
(
  input wire [18:0] lin_addr,
  input wire [1:0] mem_size,
  output reg [17:0] pin_addr
);
  // Top lines become inverted chip selects in the two smaller sizes
  always @*
  begin
    case (mem_size)
      `SSB_SZ64K: pin_addr = {1'b0, ~lin_addr[15], lin_addr[15:0]};
      `SSB_SZ128K: pin_addr = {~lin_addr[16], lin_addr[16:0]};
      default: pin_addr = lin_addr[17:0];
    endcase
  end
endmodule // ssb_addr_map

// ---- core/ssb_ctrl.v ----
// Scanner SRAM buffer controller: slot scheduler, buffer pointers, indexed registers
// Function
// - Coefficients 16K/32K, remainder is circular buffer
// - Small size: A16 is inverse of A15
// - Middle size: A17 is inverse of A16
// - Large size: eighteen linear address lines
// - Four slot modes, byte/12-bit, four/eight slots
// - Coefficients fetched every eight-cycle pixel period
// - Byte four-slot: every access two cycles
// - Byte eight-slot: one-cycle reads, four host slots
// - 12-bit samples stored as high and low bytes
// - 12-bit four-slot: host slot writes second byte
// - 12-bit eight-slot: coefficient reads one cycle each
// - 12-bit eight-slot: writes two cycles, reads one
// - Drive strength in register 43 bits 3:2
// - Index written once, many data accesses follow
// - Registers 0 to 2 are read-only
`timescale 1ns/1ps
`include "ssb_regs.vh"
module ssb_ctrl
#(
  parameter NREG = 128
)
(
  input wire sys_clk,
  input wire nrst,
  input wire [1:0] mem_size,
  input wire [1:0] slot_mode,
  input wire dpi600,
  input wire scan_en,
  input wire line_start,
  input wire pix_valid,
  input wire [11:0] pix_data,
  input wire host_rd_req,
  input wire idx_wr,
  input wire data_wr,
  input wire data_rd,
  input wire [7:0] host_wdata,
  input wire [7:0] sram_dq_in,
  output reg [17:0] sram_addr,
  output reg [7:0] sram_dq_out,
  output reg sram_dq_oe,
  output reg sram_rd_n,
  output reg sram_wr_n,
  output reg [1:0] sram_drive,
  output reg [7:0] coef_offset,
  output reg [7:0] coef_gain,
  output reg coef_valid,
  output reg [7:0] host_rd_data,
  output reg host_rd_valid,
  output reg [7:0] host_rdata,
  output reg buf_full,
  output reg buf_empty
);
  // Slot table: returns {last cycle of slot, operation}
  function [3:0] slot_op;
    input [1:0] mode;
    input [2:0] ph;
    begin
      case (mode)
        `SSB_M8S4:
          case (ph[2:1])
            2'h0: slot_op = {ph[0], `SSB_OP_OFS};
            2'h1: slot_op = {ph[0], `SSB_OP_GAIN};
            2'h2: slot_op = {ph[0], `SSB_OP_WLO};
            default: slot_op = {ph[0], `SSB_OP_HOST};
          endcase
        `SSB_M8S8:
          case (ph)
            3'h0: slot_op = {1'b1, `SSB_OP_OFS};
            3'h1: slot_op = {1'b1, `SSB_OP_GAIN};
            3'h2: slot_op = {1'b0, `SSB_OP_WLO};
            3'h3: slot_op = {1'b1, `SSB_OP_WLO};
            default: slot_op = {1'b1, `SSB_OP_HOST};
          endcase
        `SSB_M12S4:
          case (ph[2:1])
            2'h0: slot_op = {ph[0], `SSB_OP_OFS};
            2'h1: slot_op = {ph[0], `SSB_OP_GAIN};
            2'h2: slot_op = {ph[0], `SSB_OP_WHI};
            default: slot_op = {ph[0], `SSB_OP_WLO};
          endcase
        default:
          case (ph)
            3'h0: slot_op = {1'b1, `SSB_OP_OFS};
            3'h1: slot_op = {1'b1, `SSB_OP_GAIN};
            3'h2: slot_op = {1'b0, `SSB_OP_WHI};
            3'h3: slot_op = {1'b1, `SSB_OP_WHI};
            3'h4: slot_op = {1'b0, `SSB_OP_WLO};
            3'h5: slot_op = {1'b1, `SSB_OP_WLO};
            default: slot_op = {1'b1, `SSB_OP_HOST};
          endcase
      endcase
    end
  endfunction

  reg [2:0] phase_reg;
  reg act_reg;
  reg [2:0] op_d_reg;
  reg act_d_reg;
  reg last_d_reg;
  reg [18:0] wr_ptr_reg;
  reg [18:0] rd_ptr_reg;
  reg [18:0] count_reg;
  reg [17:0] coef_idx_reg;
  reg pend_reg;
  reg [11:0] pend_data_reg;
  reg [6:0] idx_reg;
  reg [7:0] cfg_reg [0:NREG-1];
  wire [3:0] cur_slot;
  wire [3:0] prev_slot;
  wire wide;
  wire first;
  reg [2:0] op;
  reg [18:0] mem_top;
  wire [18:0] coef_size;
  wire [18:0] buf_size;
  wire [18:0] bps;
  wire room;
  reg go;
  wire act;
  wire last;
  wire is_wr;
  wire is_rd;
  reg [18:0] lin_addr;
  wire [17:0] pin_addr;
  wire [7:0] wbyte;
  reg [7:0] rd_val;
  integer i;

  assign cur_slot = slot_op(slot_mode, phase_reg);
  assign prev_slot = slot_op(slot_mode, phase_reg - 3'h1);
  assign wide = slot_mode[1];
  assign first = (phase_reg == `SSB_PHASE_FIRST) | prev_slot[3];
  assign last = cur_slot[3];
  // Region split between coefficients and image buffer
  assign coef_size = dpi600 ? `SSB_COEF600 : `SSB_COEF300;
  assign buf_size = mem_top - coef_size;
  assign bps = wide ? 19'h0_0002 : 19'h0_0001;
  assign room = (count_reg + bps) <= buf_size;

  // Memory top and effective slot operation
  always @*
  begin
    case (mem_size)
      `SSB_SZ64K: mem_top = `SSB_MEM64K;
      `SSB_SZ128K: mem_top = `SSB_MEM128K;
      default: mem_top = `SSB_MEM256K;
    endcase
    op = cur_slot[2:0];
    if (slot_mode == `SSB_M12S4 && !scan_en && op == `SSB_OP_WLO)
      op = `SSB_OP_HOST;
  end

  // Slot grant decided on the first cycle of each slot
  always @*
  begin
    case (op)
      `SSB_OP_OFS: go = scan_en;
      `SSB_OP_GAIN: go = scan_en;
      `SSB_OP_WHI: go = scan_en & pend_reg & room;
      `SSB_OP_WLO: go = wide ? act_reg : (scan_en & pend_reg & room);
      `SSB_OP_HOST: go = host_rd_req & (count_reg != 19'h0_0000);
      default: go = 1'b0;
    endcase
  end
  assign act = first ? go : act_reg;
  assign is_wr = (op == `SSB_OP_WHI) | (op == `SSB_OP_WLO);
  assign is_rd = (op == `SSB_OP_OFS) | (op == `SSB_OP_GAIN) | (op == `SSB_OP_HOST);
  // High byte carries four MSBs, low byte eight LSBs
  assign wbyte = (op == `SSB_OP_WHI) ? {4'h0, pend_data_reg[11:8]} : pend_data_reg[7:0];

  // Linear address per operation
  always @*
  begin
    case (op)
      `SSB_OP_OFS: lin_addr = {coef_idx_reg, 1'b0};
      `SSB_OP_GAIN: lin_addr = {coef_idx_reg, 1'b1};
      `SSB_OP_HOST: lin_addr = coef_size + rd_ptr_reg;
      default: lin_addr = coef_size + wr_ptr_reg;
    endcase
  end

  ssb_addr_map u_map
  (
    .lin_addr(lin_addr),
    .mem_size(mem_size),
    .pin_addr(pin_addr)
  );

  // Register read value; low indices show buffer state
  always @*
  begin
    case (idx_reg)
      `SSB_REG_ST0: rd_val = count_reg[7:0];
      `SSB_REG_ST1: rd_val = count_reg[15:8];
      `SSB_REG_ST2: rd_val = {buf_full, buf_empty, 3'h0, count_reg[18:16]};
      default: rd_val = cfg_reg[idx_reg];
    endcase
  end

  // Scheduler, pointers and SRAM pins
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      phase_reg <= `SSB_PHASE_FIRST;
      act_reg <= 1'b0;
      op_d_reg <= `SSB_OP_IDLE;
      act_d_reg <= 1'b0;
      last_d_reg <= 1'b0;
      wr_ptr_reg <= 19'h0_0000;
      rd_ptr_reg <= 19'h0_0000;
      count_reg <= 19'h0_0000;
      coef_idx_reg <= 18'h0_0000;
      pend_reg <= 1'b0;
      pend_data_reg <= 12'h000;
      sram_addr <= 18'h0_0000;
      sram_dq_out <= 8'h00;
      sram_dq_oe <= 1'b0;
      sram_rd_n <= 1'b1;
      sram_wr_n <= 1'b1;
      coef_offset <= 8'h00;
      coef_gain <= 8'h00;
      coef_valid <= 1'b0;
      host_rd_data <= 8'h00;
      host_rd_valid <= 1'b0;
      buf_full <= 1'b0;
      buf_empty <= 1'b1;
    end
    else
    begin
      phase_reg <= phase_reg + 3'h1;
      act_reg <= act;
      op_d_reg <= op;
      act_d_reg <= act;
      last_d_reg <= last;
      sram_addr <= pin_addr;
      sram_dq_out <= wbyte;
      sram_dq_oe <= act & is_wr;
      sram_rd_n <= ~(act & is_rd);
      sram_wr_n <= ~(act & is_wr);
      // Pending sample; a completed low-byte write frees it, new data wins
      if (pix_valid)
      begin
        pend_reg <= 1'b1;
        pend_data_reg <= pix_data;
      end
      else if (act && last && op == `SSB_OP_WLO)
        pend_reg <= 1'b0;
      // Pointer moves at the end of each byte slot
      if (act && last && is_wr)
      begin
        wr_ptr_reg <= (wr_ptr_reg + 19'h0_0001 >= buf_size) ? 19'h0_0000 : wr_ptr_reg + 19'h0_0001;
        count_reg <= count_reg + 19'h0_0001;
      end
      else if (act && last && op == `SSB_OP_HOST)
      begin
        rd_ptr_reg <= (rd_ptr_reg + 19'h0_0001 >= buf_size) ? 19'h0_0000 : rd_ptr_reg + 19'h0_0001;
        count_reg <= count_reg - 19'h0_0001;
      end
      // Coefficient index per pixel, wrapping inside its region
      if (line_start)
        coef_idx_reg <= 18'h0_0000;
      else if (act && last && op == `SSB_OP_GAIN)
        coef_idx_reg <= ({coef_idx_reg, 1'b1} + 19'h0_0001 >= coef_size) ? 18'h0_0000 : coef_idx_reg + 18'h0_0001;
      // Read data captured one cycle after the slot's last cycle
      coef_valid <= 1'b0;
      host_rd_valid <= 1'b0;
      if (act_d_reg && last_d_reg)
      begin
        case (op_d_reg)
          `SSB_OP_OFS: coef_offset <= sram_dq_in;
          `SSB_OP_GAIN:
          begin
            coef_gain <= sram_dq_in;
            coef_valid <= 1'b1;
          end
          `SSB_OP_HOST:
          begin
            host_rd_data <= sram_dq_in;
            host_rd_valid <= 1'b1;
          end
          default: coef_valid <= 1'b0;
        endcase
      end
      buf_full <= ~room;
      buf_empty <= (count_reg == 19'h0_0000);
    end
  end

  // Indexed register access and drive setting
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      idx_reg <= 7'h00;
      host_rdata <= 8'h00;
      sram_drive <= 2'h0;
      for (i = 0; i < NREG; i = i + 1)
        cfg_reg[i] <= `SSB_REG_RST;
    end
    else
    begin
      if (idx_wr)
        idx_reg <= host_wdata[6:0];
      else if (data_wr && idx_reg > `SSB_RO_LAST)
        cfg_reg[idx_reg] <= host_wdata;
      if (data_rd)
        host_rdata <= rd_val;
      sram_drive <= cfg_reg[`SSB_REG_DRIVE][`SSB_DRV_MSB:`SSB_DRV_LSB];
    end
  end
endmodule // ssb_ctrl

// ---- dv/ssb_ctrl_properties.sv ----
// Port checks for the scanner SRAM buffer controller
`timescale 1ns/1ps
module ssb_ctrl_checker
(
  input wire sys_clk,
  input wire nrst,
  input wire [1:0] mem_size,
  input wire [1:0] slot_mode,
  input wire scan_en,
  input wire [17:0] sram_addr,
  input wire sram_rd_n,
  input wire sram_wr_n,
  input wire coef_valid,
  input wire host_rd_valid
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Any SRAM access in progress
  wire strobe = !sram_rd_n || !sram_wr_n;
  // Write strobe starting in a given slot mode
  sequence wr_start_s(m);
    slot_mode == m && $fell(sram_wr_n);
  endsequence
  addr_small_a: assert property (strobe && mem_size == 2'h0 |-> sram_addr[16] == !sram_addr[15])
    else $error("upper select wrong in small size");
  addr_mid_a: assert property (strobe && mem_size == 2'h1 |-> sram_addr[17] == !sram_addr[16])
    else $error("upper select wrong in middle size");
  rd_two_a: assert property (slot_mode == 2'h0 && $fell(sram_rd_n) |=> !sram_rd_n)
    else $error("short read strobe");
  wr_two_a: assert property (wr_start_s(2'h0) |=> !sram_wr_n ##1 sram_wr_n)
    else $error("byte write not two cycles");
  wr_wide_a: assert property (wr_start_s(2'h3) |=> !sram_wr_n [*3] ##1 sram_wr_n)
    else $error("sample write not four cycles");
  host_once_a: assert property (host_rd_valid && slot_mode == 2'h0 |=> !host_rd_valid [*7])
    else $error("extra host read in period");
  coef_gap_a: assert property (coef_valid |=> !coef_valid [*7])
    else $error("coefficients too often");
  coef_rate_a: assert property (coef_valid && scan_en ##1 scan_en [*7] |=> coef_valid)
    else $error("coefficient pair missing");
  no_host12_a: assert property ((slot_mode == 2'h2 && scan_en) [*5] |-> !host_rd_valid)
    else $error("host read while scanning");
endmodule // ssb_ctrl_checker
bind ssb_ctrl ssb_ctrl_checker u_ssb_ctrl_checker (.sys_clk(sys_clk), .nrst(nrst), .mem_size(mem_size),
  .slot_mode(slot_mode), .scan_en(scan_en), .sram_addr(sram_addr), .sram_rd_n(sram_rd_n),
  .sram_wr_n(sram_wr_n), .coef_valid(coef_valid), .host_rd_valid(host_rd_valid));

// ---- dv/ssb_sram_model.sv ----
// Behavioural byte-wide asynchronous SRAM
`timescale 1ns/1ps
module ssb_sram_model
(
  input wire clk,
  input wire [17:0] addr,
  input wire [7:0] din,
  input wire oe,
  input wire rd_n,
  input wire wr_n,
  output wire [7:0] dout
);
  logic [7:0] mem [0:262143];
  logic [7:0] last_q = 8'h00;
  // Known contents so coefficient reads are predictable
  initial foreach (mem[i]) mem[i] = 8'(i) ^ 8'h5A;
  // Idle bus shows the inverse of the last value, never a stale copy
  assign dout = !rd_n ? mem[addr] : ~last_q;
  // Store while written and driven
  always @(posedge clk)
  begin
    if (!wr_n && oe) mem[addr] <= din;
    if (!rd_n) last_q <= mem[addr];
  end
endmodule // ssb_sram_model

// ---- dv/ssb_ctrl_test.sv ----
// Self-checking bench for the scanner SRAM buffer controller
`timescale 1ns/1ps
module ssb_ctrl_test;
  logic sys_clk, nrst, dpi600, scan_en, line_start, pix_valid, host_rd_req, idx_wr, data_wr, data_rd, cseen;
  logic [1:0] mem_size, slot_mode, sram_drive;
  logic [11:0] pix_data, pd;
  logic [7:0] host_wdata, sram_dq_in, sram_dq_out, coef_offset, coef_gain, host_rd_data, host_rdata, rv, cof, cgn;
  logic [17:0] sram_addr;
  logic sram_dq_oe, sram_rd_n, sram_wr_n, coef_valid, host_rd_valid, buf_full, buf_empty;
  int mismatches = 0;
  int num_checks = 0;
  int t0, tl, n;
  logic [7:0] q [$];
  localparam logic [17:0] pa_tab [4] = '{18'h1_4000, 18'h2_4000, 18'h0_4000, 18'h0_8000};
  localparam int span_lo [4] = '{24, 3, 56, 25};
  localparam int span_hi [4] = '{24, 7, 56, 31};
  ssb_ctrl u_ssb_ctrl (.sys_clk(sys_clk), .nrst(nrst), .mem_size(mem_size), .slot_mode(slot_mode),
    .dpi600(dpi600), .scan_en(scan_en), .line_start(line_start), .pix_valid(pix_valid), .pix_data(pix_data),
    .host_rd_req(host_rd_req), .idx_wr(idx_wr), .data_wr(data_wr), .data_rd(data_rd), .host_wdata(host_wdata),
    .sram_dq_in(sram_dq_in), .sram_addr(sram_addr), .sram_dq_out(sram_dq_out), .sram_dq_oe(sram_dq_oe),
    .sram_rd_n(sram_rd_n), .sram_wr_n(sram_wr_n), .sram_drive(sram_drive), .coef_offset(coef_offset),
    .coef_gain(coef_gain), .coef_valid(coef_valid), .host_rd_data(host_rd_data),
    .host_rd_valid(host_rd_valid), .host_rdata(host_rdata), .buf_full(buf_full), .buf_empty(buf_empty));
  ssb_sram_model u_ssb_sram_model (.clk(sys_clk), .addr(sram_addr), .din(sram_dq_out), .oe(sram_dq_oe),
    .rd_n(sram_rd_n), .wr_n(sram_wr_n), .dout(sram_dq_in));
  // 20 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // First coefficient pair after each reset
  always @(posedge sys_clk)
  begin
    if (!nrst)
      cseen <= 1'b0;
    else if (coef_valid === 1'b1 && !cseen)
    begin
      cof <= coef_offset;
      cgn <= coef_gain;
      cseen <= 1'b1;
    end
  end
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Host register access, one pulse each
  task automatic set_idx(input logic [7:0] i);
    idx_wr <= 1'b1;
    host_wdata <= i;
    @(posedge sys_clk);
    idx_wr <= 1'b0;
  endtask
  task automatic reg_wr(input logic [7:0] d);
    data_wr <= 1'b1;
    host_wdata <= d;
    @(posedge sys_clk);
    data_wr <= 1'b0;
  endtask
  task automatic reg_rd(output logic [7:0] d);
    data_rd <= 1'b1;
    @(posedge sys_clk);
    data_rd <= 1'b0;
    @(negedge sys_clk);
    d = host_rdata;
    @(posedge sys_clk);
  endtask
  task automatic do_reset;
    nrst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    // Return on a pixel period boundary so a scan starts at phase 0
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Drive setting, then each slot mode: scan, registers, drain
  initial
  begin
    {dpi600, scan_en, line_start, pix_valid, host_rd_req, idx_wr, data_wr, data_rd} = '0;
    {mem_size, slot_mode, pix_data, host_wdata} = '0;
    do_reset;
    for (int v = 0; v < 4; v++)
    begin
      set_idx(8'h43);
      reg_wr(8'(v << 2));
      reg_rd(rv);
      chk8(rv, 8'(v << 2));
      chk8({6'h0, sram_drive}, 8'(v));
    end
    $display("drive test done");
    for (int m = 0; m < 4; m++)
    begin
      slot_mode <= m[1:0];
      mem_size <= (m == 0) ? 2'h0 : (m == 1) ? 2'h1 : 2'h2;
      dpi600 <= (m == 3);
      do_reset;
      line_start <= 1'b1;
      scan_en <= 1'b1;
      host_rd_req <= (m == 2);
      q = {};
      for (int i = 0; i < 4; i++)
      begin
        pd = 12'h05A3 ^ 12'(i * 'h1F1);
        pix_valid <= 1'b1;
        pix_data <= pd;
        if (m[1]) q.push_back({4'h0, pd[11:8]});
        q.push_back(pd[7:0]);
        @(posedge sys_clk);
        pix_valid <= 1'b0;
        line_start <= 1'b0;
        repeat (7) @(posedge sys_clk);
      end
      chk8(u_ssb_sram_model.mem[pa_tab[m]], q[0]);
      chk8(cof, 8'h5A);
      chk8(cgn, 8'h5B);
      set_idx(8'h00);
      reg_rd(rv);
      chk8(rv, 8'(q.size()));
      reg_wr(8'h55);
      reg_rd(rv);
      chk8(rv, 8'(q.size()));
      set_idx(8'h02);
      reg_rd(rv);
      chk8(rv, 8'h00);
      scan_en <= 1'b0;
      host_rd_req <= 1'b1;
      n = 0;
      for (int c = 0; c < 300; c++)
      begin
        @(negedge sys_clk);
        if (host_rd_valid === 1'b1)
        begin
          if (n == 0) t0 = c;
          tl = c;
          n++;
          chk8(host_rd_data, (q.size() > 0) ? q.pop_front() : 8'hxx);
        end
      end
      chk8({7'h0, buf_empty}, 8'h01);
      chk8(8'(q.size()), 8'h00);
      chk8({7'h0, tl - t0 >= span_lo[m] && tl - t0 <= span_hi[m]}, 8'h01);
      @(posedge sys_clk);
      host_rd_req <= 1'b0;
      $display("mode %0d test done", m);
    end
    test_done;
  end
  // Hang guard, well past the expected run of about 1450 cycles
  initial
  begin
    #500_000;
    mismatches++;
    test_done;
  end
endmodule // ssb_ctrl_test
